/* src/selftest_pkg.sv */
package selftest_pkg;
	// Data path and memory geometry
	localparam int DATA_W = 16;
	localparam int ADDR_W = 15;
	localparam int NUM_SCRATCH = 16;
	localparam int CU_ADDR_W = 8;
	// Result codes shown on the panel
	localparam logic [3:0] CODE_NONE = 4'h0;
	localparam logic [3:0] CODE_CPU_FAIL = 4'h1;
	localparam logic [3:0] CODE_CU_FAIL = 4'h2;
	localparam logic [3:0] CODE_MEM_FAIL = 4'h3;
	localparam logic [3:0] CODE_PASS = 4'h4;
	// Condition register codes
	localparam logic [1:0] COND_ZERO = 2'h0;
	localparam logic [1:0] COND_OVERFLOW = 2'h3;
	// Memory and scratchpad patterns
	localparam logic [15:0] PAT_ZEROS = 16'h0000;
	localparam logic [15:0] PAT_ONES = 16'hFFFF;
	localparam logic [15:0] NIBBLE_REP = 16'h1111;
	// Scratchpad slots used to report a memory miscompare
	localparam logic [3:0] SLOT_ADDR = 4'h0;
	localparam logic [3:0] SLOT_EXP = 4'h1;
	localparam logic [3:0] SLOT_GOT = 4'h2;
	// Operand used by the processor checks
	localparam logic [15:0] OP_SEED = 16'hA5C3;
	localparam logic [15:0] OP_SHIFT = 16'h4001;

	typedef enum {
		ST_IDLE, ST_CPU, ST_CU_REQ, ST_CU_WAIT, ST_MEM_WR, ST_MEM_RD,
		ST_MEM_CHK, ST_RESTORE, ST_DONE
	} state_type;
endpackage : selftest_pkg

/* src/processor_memory_self_test.sv */
// Functional notes
// - Phases run CPU, control unit, memory, report
// - One run per trigger, never loops
// - Check bus lines stuck and logic ops
// - Arithmetic left shift leaves overflow code
// - Scratchpad holds index repeated per digit
// - First phase failure shows code one, halts
// - Halt command; nonzero condition shows code two
// - Memory zeros then ones write and check
// - Third pass writes address as data
// - Memory miscompare shows code three, halts
// - Memory failure leaves address, expected, read in slots
// - Pass shows code four, scratchpad restored
// - Memory accesses are full words only
`timescale 1ns/10ps
module processor_memory_self_test (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	// Panel controls
	input  wire logic        masterClearKey,
	input  wire logic        startTest,
	input  wire logic        handHeldPanel,
	input  wire logic [7:0]  cuAddress,
	output logic      [3:0]  resultCode,
	output logic             testBusy,
	// Scratchpad inspection port
	input  wire logic [3:0]  scratchSel,
	output logic      [15:0] scratchData,
	// Processor bus loop-back
	output logic      [15:0] busDriveOut,
	input  wire logic [15:0] busSenseIn,
	// Control unit command port
	output logic             cuHaltReq,
	output logic      [7:0]  cuHaltAddr,
	input  wire logic        cuDone,
	input  wire logic [1:0]  cuCondition,
	// Main memory, word access only
	output logic             memReq,
	output logic             memWrite,
	output logic             memWordMode,
	output logic      [14:0] memAddr,
	output logic      [15:0] memWdata,
	input  wire logic        memAck,
	input  wire logic [15:0] memRdata
);
	selftest_pkg::state_type stateReg;
	logic [15:0] scratchReg [selftest_pkg::NUM_SCRATCH];
	logic [1:0]  conditionRegister;
	logic [3:0]  stepReg;
	logic [1:0]  passReg;
	logic [14:0] addrReg;
	logic [15:0] expected;
	logic [15:0] rotL, rotR, logical_shift_left_op, double_rotate_left_op;
	logic [16:0] arith_shift_left_op;
	logic        cpuOk;
	logic        lastAddr;
	logic        trigPrev;
	logic        trigEdge;

	// Trigger edge so one press gives exactly one run
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			trigPrev <= 1'b0;
		else
			trigPrev <= startTest;
	end
	assign trigEdge = startTest && !trigPrev;

	// Operation results for the processor checks
	always_comb begin
		rotL = {busSenseIn[14:0], busSenseIn[15]};
		rotR = {busSenseIn[0], busSenseIn[15:1]};
		logical_shift_left_op  = {busSenseIn[14:0], 1'b0};
		double_rotate_left_op  = {busSenseIn[13:0], busSenseIn[15:14]};
		arith_shift_left_op  = {selftest_pkg::OP_SHIFT, 1'b0};
	end

	// Per-step pass check of bus lines and operations
	always_comb begin
		unique case (stepReg)
			4'h0: cpuOk = busSenseIn == selftest_pkg::PAT_ZEROS;
			4'h1: cpuOk = busSenseIn == selftest_pkg::PAT_ONES;
			4'h2: cpuOk = (busSenseIn & selftest_pkg::PAT_ONES)
				== selftest_pkg::OP_SEED;
			4'h3: cpuOk = (busSenseIn | selftest_pkg::PAT_ZEROS)
				== selftest_pkg::OP_SEED;
			4'h4: cpuOk = (busSenseIn ^ selftest_pkg::OP_SEED)
				== selftest_pkg::PAT_ZEROS;
			4'h5: cpuOk = {rotR[14:0], rotR[15]} == busSenseIn;
			4'h6: cpuOk = {rotL[0], rotL[15:1]} == busSenseIn;
			4'h7: cpuOk = logical_shift_left_op[15:1] == busSenseIn[14:0];
			4'h8: cpuOk = {double_rotate_left_op[1:0], double_rotate_left_op[15:2]} == busSenseIn;
			default: cpuOk = arith_shift_left_op[16] != arith_shift_left_op[15];
		endcase
	end

	// Bus drive pattern for each check step
	always_comb begin
		unique case (stepReg)
			4'h0: busDriveOut = selftest_pkg::PAT_ZEROS;
			4'h1: busDriveOut = selftest_pkg::PAT_ONES;
			default: busDriveOut = selftest_pkg::OP_SEED;
		endcase
	end

	// Pattern for the current memory pass
	always_comb begin
		unique case (passReg)
			2'h0: expected = selftest_pkg::PAT_ZEROS;
			2'h1: expected = selftest_pkg::PAT_ONES;
			default: expected = {1'b0, addrReg};
		endcase
	end
	assign lastAddr = &addrReg;

	// Phase sequencer
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			stateReg <= selftest_pkg::ST_IDLE;
			stepReg  <= 4'h0;
			passReg  <= 2'h0;
			addrReg  <= '0;
		end else if (masterClearKey) begin
			stateReg <= selftest_pkg::ST_IDLE;
		end else begin
			unique case (stateReg)
				selftest_pkg::ST_IDLE, selftest_pkg::ST_DONE: begin
					if (trigEdge) begin
						stateReg <= selftest_pkg::ST_CPU;
						stepReg  <= 4'h0;
					end
				end
				selftest_pkg::ST_CPU: begin
					if (!cpuOk)
						stateReg <= selftest_pkg::ST_DONE;
					else if (stepReg == 4'h9) begin
						passReg <= 2'h0;
						addrReg <= '0;
						stateReg <= handHeldPanel
							? selftest_pkg::ST_CU_REQ
							: selftest_pkg::ST_MEM_WR;
					end else
						stepReg <= stepReg + 4'h1;
				end
				selftest_pkg::ST_CU_REQ:
					stateReg <= selftest_pkg::ST_CU_WAIT;
				selftest_pkg::ST_CU_WAIT: begin
					if (cuDone)
						stateReg <= (cuCondition == selftest_pkg::COND_ZERO)
							? selftest_pkg::ST_MEM_WR
							: selftest_pkg::ST_DONE;
				end
				selftest_pkg::ST_MEM_WR: begin
					if (memAck) begin
						addrReg <= addrReg + 15'h1;
						if (lastAddr)
							stateReg <= selftest_pkg::ST_MEM_RD;
					end
				end
				selftest_pkg::ST_MEM_RD: begin
					if (memAck) begin
						if (memRdata != expected)
							stateReg <= selftest_pkg::ST_DONE;
						else if (lastAddr) begin
							addrReg <= '0;
							if (passReg == 2'h2)
								stateReg <= selftest_pkg::ST_RESTORE;
							else begin
								passReg  <= passReg + 2'h1;
								stateReg <= selftest_pkg::ST_MEM_WR;
							end
						end else
							addrReg <= addrReg + 15'h1;
					end
				end
				selftest_pkg::ST_RESTORE:
					stateReg <= selftest_pkg::ST_DONE;
				default: stateReg <= selftest_pkg::ST_IDLE;
			endcase
		end
	end

	// Result code shown on the active panel
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			resultCode <= selftest_pkg::CODE_NONE;
		else if (trigEdge && (stateReg == selftest_pkg::ST_IDLE
				|| stateReg == selftest_pkg::ST_DONE))
			resultCode <= selftest_pkg::CODE_NONE;
		else if (stateReg == selftest_pkg::ST_CPU && !cpuOk)
			resultCode <= selftest_pkg::CODE_CPU_FAIL;
		else if (stateReg == selftest_pkg::ST_CU_WAIT && cuDone
				&& cuCondition != selftest_pkg::COND_ZERO)
			resultCode <= selftest_pkg::CODE_CU_FAIL;
		else if (stateReg == selftest_pkg::ST_MEM_RD && memAck
				&& memRdata != expected)
			resultCode <= selftest_pkg::CODE_MEM_FAIL;
		else if (stateReg == selftest_pkg::ST_RESTORE)
			resultCode <= selftest_pkg::CODE_PASS;
	end

	// Condition register from the shift check and the halt answer
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			conditionRegister <= selftest_pkg::COND_ZERO;
		else if (stateReg == selftest_pkg::ST_CPU && stepReg == 4'h9
				&& cpuOk)
			conditionRegister <= selftest_pkg::COND_OVERFLOW;
		else if (stateReg == selftest_pkg::ST_CU_WAIT && cuDone)
			conditionRegister <= cuCondition;
	end

	// Scratchpad fill and miscompare capture
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < selftest_pkg::NUM_SCRATCH; i++)
				scratchReg[i] <= '0;
		end else if ((stateReg == selftest_pkg::ST_CPU && stepReg == 4'h9
				&& cpuOk) || stateReg == selftest_pkg::ST_RESTORE) begin
			for (int i = 0; i < selftest_pkg::NUM_SCRATCH; i++)
				scratchReg[i] <= selftest_pkg::NIBBLE_REP
					* 16'(i);
		end else if (stateReg == selftest_pkg::ST_MEM_RD && memAck
				&& memRdata != expected) begin
			scratchReg[selftest_pkg::SLOT_ADDR] <= {1'b0, addrReg};
			scratchReg[selftest_pkg::SLOT_EXP]  <= expected;
			scratchReg[selftest_pkg::SLOT_GOT]  <= memRdata;
		end
	end

	// Outputs
	assign scratchData = scratchReg[scratchSel];
	assign testBusy = stateReg != selftest_pkg::ST_IDLE
		&& stateReg != selftest_pkg::ST_DONE;
	assign cuHaltReq = stateReg == selftest_pkg::ST_CU_REQ;
	assign cuHaltAddr = cuAddress;
	assign memReq = stateReg == selftest_pkg::ST_MEM_WR
		|| stateReg == selftest_pkg::ST_MEM_RD;
	assign memWrite = stateReg == selftest_pkg::ST_MEM_WR;
	assign memWordMode = 1'b1;
	assign memAddr = addrReg;
	assign memWdata = expected;

	a_cpu_fail_code: assert property (@(posedge core_clk) disable iff (!arst_n)
		stateReg == selftest_pkg::ST_CPU && !cpuOk && !masterClearKey
		|=> resultCode == selftest_pkg::CODE_CPU_FAIL
		&& stateReg == selftest_pkg::ST_DONE)
		else $error("cpu failure code wrong");
	a_cu_fail_code: assert property (@(posedge core_clk) disable iff (!arst_n)
		stateReg == selftest_pkg::ST_CU_WAIT && cuDone && !masterClearKey
		&& cuCondition != selftest_pkg::COND_ZERO
		|=> resultCode == selftest_pkg::CODE_CU_FAIL
		&& conditionRegister != selftest_pkg::COND_ZERO)
		else $error("control unit failure code wrong");
	a_mem_fail_code: assert property (@(posedge core_clk) disable iff (!arst_n)
		stateReg == selftest_pkg::ST_MEM_RD && memAck && !masterClearKey
		&& memRdata != expected |=> resultCode == selftest_pkg::CODE_MEM_FAIL
		&& scratchReg[selftest_pkg::SLOT_GOT] == $past(memRdata))
		else $error("memory failure not reported");
	a_pass_pattern: assert property (@(posedge core_clk) disable iff (!arst_n)
		stateReg == selftest_pkg::ST_RESTORE && !masterClearKey
		|=> resultCode == selftest_pkg::CODE_PASS
		&& scratchReg[15] == selftest_pkg::PAT_ONES)
		else $error("pass report wrong");
	a_word_mode: assert property (@(posedge core_clk) disable iff (!arst_n)
		memReq |-> memWordMode)
		else $error("character access issued");
	a_no_loop: assert property (@(posedge core_clk) disable iff (!arst_n)
		stateReg == selftest_pkg::ST_DONE && !trigEdge
		|=> stateReg != selftest_pkg::ST_CPU)
		else $error("test restarted without trigger");
	a_skip_cu: assert property (@(posedge core_clk) disable iff (!arst_n)
		stateReg == selftest_pkg::ST_CPU && cpuOk && stepReg == 4'h9
		&& !handHeldPanel && !masterClearKey
		|=> stateReg == selftest_pkg::ST_MEM_WR)
		else $error("command phase not skipped");
	a_overflow_code: assert property (@(posedge core_clk) disable iff (!arst_n)
		stateReg == selftest_pkg::ST_CPU && cpuOk && stepReg == 4'h9
		|=> conditionRegister == selftest_pkg::COND_OVERFLOW
		&& scratchReg[1] == selftest_pkg::NIBBLE_REP)
		else $error("overflow code or scratchpad wrong");
	a_third_pass: assert property (@(posedge core_clk) disable iff (!arst_n)
		memWrite && passReg == 2'h2 |-> memWdata == {1'b0, memAddr})
		else $error("address pattern wrong");
	a_bus_stuck: assert property (@(posedge core_clk) disable iff (!arst_n)
		stateReg == selftest_pkg::ST_CPU && stepReg == 4'h1
		&& busSenseIn != selftest_pkg::PAT_ONES && !masterClearKey
		|=> stateReg == selftest_pkg::ST_DONE)
		else $error("stuck bus line missed");

	c_pass: cover property (@(posedge core_clk)
		resultCode == selftest_pkg::CODE_PASS);
	c_mem_fail: cover property (@(posedge core_clk)
		resultCode == selftest_pkg::CODE_MEM_FAIL);
	c_cu_fail: cover property (@(posedge core_clk)
		resultCode == selftest_pkg::CODE_CU_FAIL);
endmodule : processor_memory_self_test

/* test/board_model.sv */
`timescale 1ns/10ps
module board_model (
	// Clock
	input  wire logic        core_clk,
	// Memory side
	input  wire logic        memReq,
	input  wire logic        memWrite,
	input  wire logic [14:0] memAddr,
	input  wire logic [15:0] memWdata,
	output logic             memAck,
	output logic      [15:0] memRdata,
	input  wire logic        stall,
	input  wire logic [14:0] faultAddr,
	input  wire logic [15:0] faultLo,
	input  wire logic [15:0] faultHi,
	// Control unit side
	input  wire logic        cuHaltReq,
	output logic             cuDone,
	output logic      [1:0]  cuCondition,
	input  wire logic [1:0]  condSet,
	// Bus loop-back
	input  wire logic [15:0] busDriveOut,
	output logic      [15:0] busSenseIn,
	input  wire logic [15:0] stuckLo,
	input  wire logic [15:0] stuckHi
);
	logic [15:0] store [0:32767];
	logic [15:0] rdVal;
	// Word store, full words only
	always_ff @(posedge core_clk) begin
		if (memReq && memAck && memWrite) begin
			store[memAddr] <= memWdata;
		end
	end
	// Prompt answer unless stalled; faulty cell at one address
	assign memAck = memReq & ~stall;
	assign rdVal = (memAddr == faultAddr) ?
		((store[memAddr] & ~faultLo) | faultHi) : store[memAddr];
	assign memRdata = memAck ? rdVal : ~rdVal;
	// Halt answered one cycle later; condition invalid outside it
	always_ff @(posedge core_clk) begin
		cuDone <= cuHaltReq;
	end
	assign cuCondition = cuDone ? condSet : ~condSet;
	// Bus lines with stuck faults
	assign busSenseIn = (busDriveOut | stuckHi) & ~stuckLo;
endmodule : board_model

/* test/testbench.sv */
`timescale 1ns/10ps
module testbench;
	logic        core_clk, arst_n, masterClearKey, startTest;
	logic        handHeldPanel, testBusy, cuHaltReq, cuDone;
	logic        memReq, memWrite, memWordMode, memAck, stall;
	logic [7:0]  cuAddress, cuHaltAddr, haltAddr;
	logic [3:0]  resultCode, scratchSel;
	logic [1:0]  cuCondition, condSet;
	logic [14:0] memAddr, faultAddr;
	logic [15:0] scratchData, busDriveOut, busSenseIn, memWdata, memRdata;
	logic [15:0] faultLo, faultHi, stuckLo, stuckHi, m;
	int          fails, check_count, haltCount, wideBad;
	processor_memory_self_test dut (.core_clk(core_clk), .arst_n(arst_n),
		.masterClearKey(masterClearKey), .startTest(startTest),
		.handHeldPanel(handHeldPanel), .cuAddress(cuAddress),
		.resultCode(resultCode), .testBusy(testBusy),
		.scratchSel(scratchSel), .scratchData(scratchData),
		.busDriveOut(busDriveOut), .busSenseIn(busSenseIn),
		.cuHaltReq(cuHaltReq), .cuHaltAddr(cuHaltAddr), .cuDone(cuDone),
		.cuCondition(cuCondition), .memReq(memReq), .memWrite(memWrite),
		.memWordMode(memWordMode), .memAddr(memAddr), .memWdata(memWdata),
		.memAck(memAck), .memRdata(memRdata));
	board_model far (.core_clk(core_clk), .memReq(memReq),
		.memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata),
		.memAck(memAck), .memRdata(memRdata), .stall(stall),
		.faultAddr(faultAddr), .faultLo(faultLo), .faultHi(faultHi),
		.cuHaltReq(cuHaltReq), .cuDone(cuDone), .cuCondition(cuCondition),
		.condSet(condSet), .busDriveOut(busDriveOut),
		.busSenseIn(busSenseIn), .stuckLo(stuckLo), .stuckHi(stuckHi));
	// Clock
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	// Monitors of halt commands and word mode; random memory stalls
	always @(posedge core_clk) begin
		if (cuHaltReq === 1'b1) begin
			haltCount++;
			haltAddr = cuHaltAddr;
		end
		if (memReq === 1'b1 && memWordMode !== 1'b1) wideBad++;
		stall <= ($urandom % 32 == 0);
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : report_and_stop
	function automatic logic [15:0] idxPat(input logic [3:0] i);
		return 16'h1111 * i;
	endfunction : idxPat
	// Panel sequence: clear, address, then test key rise
	task automatic trig(input logic hand_held_panel);
		@(posedge core_clk) #1;
		masterClearKey = 1'b1;
		handHeldPanel = hand_held_panel;
		cuAddress = $urandom;
		haltCount = 0;
		@(posedge core_clk) #1;
		masterClearKey = 1'b0;
		startTest = 1'b0;
		@(posedge core_clk) #1;
		startTest = 1'b1;
	endtask : trig
	task automatic run(input logic hand_held_panel, input int bound);
		int n;
		trig(hand_held_panel);
		for (n = 0; n < bound && (n < 2 || testBusy !== 1'b0); n++) begin
			@(posedge core_clk) #1;
		end
		if (n == bound) begin
			fails++;
			report_and_stop();
		end
		$display("test done code %h", resultCode);
	endtask : run
	task automatic scr(input logic [3:0] i, input logic [15:0] exp);
		scratchSel = i;
		#1;
		check(scratchData, exp);
	endtask : scr
	initial begin
		void'($urandom(62775));
		{arst_n, masterClearKey, startTest, handHeldPanel} = 4'h0;
		{cuAddress, scratchSel, condSet} = 14'h0000;
		{faultAddr, faultLo, faultHi, stuckLo, stuckHi} = 79'h0;
		{fails, check_count, haltCount, wideBad} = 128'h0;
		repeat (5) @(posedge core_clk);
		#1 arst_n = 1'b1;
		// Stuck low then stuck high bus line
		for (int k = 0; k < 2; k++) begin
			m = 16'h0001 << ($urandom % 16);
			stuckLo = k ? 16'h0000 : m;
			stuckHi = k ? m : 16'h0000;
			run(1'b1, 100);
			check(resultCode, selftest_pkg::CODE_CPU_FAIL);
			check(haltCount, 0);
		end
		{stuckLo, stuckHi} = 32'h0;
		// Halt refused by the control unit
		condSet = 2'h1 + ($urandom % 3);
		run(1'b1, 200);
		check(resultCode, selftest_pkg::CODE_CU_FAIL);
		check(haltCount, 1);
		check(haltAddr, cuAddress);
		for (int i = 0; i < 16; i++) scr(i, idxPat(i));
		condSet = 2'h0;
		// Abort by master clear, no rerun while key stays high
		trig(1'b0);
		repeat (4) @(posedge core_clk) #1;
		check(testBusy, 1'b1);
		masterClearKey = 1'b1;
		@(posedge core_clk) #1;
		masterClearKey = 1'b0;
		repeat (10) @(posedge core_clk) #1;
		check(testBusy, 1'b0);
		check(resultCode, selftest_pkg::CODE_NONE);
		$display("test done abort code %h", resultCode);
		// One bit stuck high in the zeros pass, no panel fitted
		faultAddr = $urandom % 64;
		faultHi = 16'h0001 << ($urandom % 16);
		run(1'b0, 40000);
		check(resultCode, selftest_pkg::CODE_MEM_FAIL);
		check(haltCount, 0);
		scr(selftest_pkg::SLOT_ADDR, {1'b0, faultAddr});
		scr(selftest_pkg::SLOT_EXP, selftest_pkg::PAT_ZEROS);
		scr(selftest_pkg::SLOT_GOT, faultHi);
		// Bits stuck low show only in the ones pass
		faultHi = 16'h0000;
		faultAddr = 15'h0003;
		faultLo = $urandom | 16'h0100;
		run(1'b1, 105000);
		check(resultCode, selftest_pkg::CODE_MEM_FAIL);
		check(haltCount, 1);
		scr(selftest_pkg::SLOT_ADDR, 16'h0003);
		scr(selftest_pkg::SLOT_EXP, selftest_pkg::PAT_ONES);
		scr(selftest_pkg::SLOT_GOT, ~faultLo);
		check(wideBad, 0);
		report_and_stop();
	end
endmodule : testbench
